//--- host_pwr_pkg.sv
// Purpose: Shared constants for the host power supervisor
// Assumes: 25 MHz module clock, 1/32 s timing tick
// Notes:   Times are kept in ms, tick counts derive from them
package host_pwr_pkg;

	// ==========================================================
	// Clock and timing
	localparam int CLK_HZ        = 25_000_000;
	localparam int TICK_HZ       = 32;
	localparam int TICK_DIV      = CLK_HZ / TICK_HZ;
	localparam int RST_PULSE_MS  = 1000;
	localparam int PWRON_HOLD_MS = 250;
	localparam int LONG_HOLD_MS  = 4000;
	localparam int EXTEND_MS     = 5000;
	localparam int SECOND_MS     = 1000;
	// Least times round up, longest times round down
	localparam logic [7:0] RST_PULSE_TICKS  = 8'((RST_PULSE_MS * TICK_HZ + 999) / 1000);
	localparam logic [7:0] PWRON_HOLD_TICKS = 8'((PWRON_HOLD_MS * TICK_HZ + 999) / 1000);
	localparam logic [7:0] LONG_HOLD_TICKS  = 8'((LONG_HOLD_MS * TICK_HZ + 999) / 1000);
	localparam logic [7:0] EXTEND_TICKS     = 8'((EXTEND_MS * TICK_HZ) / 1000);
	localparam logic [4:0] SECOND_LAST_TICK = 5'((SECOND_MS * TICK_HZ) / 1000 - 1);

	// ==========================================================
	// Function mask bits
	localparam int MASK_RST_INV   = 1;
	localparam int MASK_PWR_INV   = 2;
	localparam int MASK_WD_ACTIVE = 3;
	localparam int MASK_BLANK     = 4;
	localparam int MASK_KEY_RST   = 5;
	localparam int MASK_KEY_PON   = 6;
	localparam int MASK_KEY_POFF  = 7;
	localparam logic [7:0] MASK_RESET      = 8'h00;
	localparam logic [7:0] PULSE_LEN_RESET = 8'h20;

	// ==========================================================
	// Packet types and reply layout
	localparam logic [7:0] CMD_PWR_FUNC = 8'h1C;
	localparam logic [7:0] CMD_WATCHDOG = 8'h1D;
	localparam logic [7:0] CMD_STATUS   = 8'h1E;
	localparam logic [7:0] ACK_FLAG     = 8'h40;
	localparam logic [7:0] STATUS_LEN   = 8'h0F;

	// ==========================================================
	// Register map (byte addresses) and fields
	localparam logic [7:0] REG_CMD   = 8'h00;
	localparam logic [7:0] REG_REPLY = 8'h04;
	localparam logic [7:0] REG_STAT  = 8'h08;
	localparam logic [7:0] REG_LIVE  = 8'h0C;
	localparam int CMD_TYPE_LSB  = 0;
	localparam int CMD_D0_LSB    = 8;
	localparam int CMD_D1_LSB    = 16;
	localparam int CMD_LEN_LSB   = 24;
	localparam int REPLY_VLD_BIT = 16;
	localparam int REPLY_ERR_BIT = 17;

	// ==========================================================
	// Control states
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_RST  = 4'h2,
		ST_PON  = 4'h4,
		ST_POFF = 4'h8
	} ctl_state_t;

endpackage : host_pwr_pkg

//--- pulse_if.sv
// Purpose: Bundle between controller and one line pulse driver
// Assumes: Single clock domain
// Notes:   Pin level is only meaningful while pin_oe is high
`timescale 1ns/1ns
`default_nettype none
interface pulse_if;
	logic       start;
	logic [7:0] len;
	logic [7:0] ext_max;
	logic       hold;
	logic       invert;
	logic       busy;
	logic       done;
	logic       pin_o;
	logic       pin_oe;

	modport drv (
		input  start, len, ext_max, hold, invert,
		output busy, done, pin_o, pin_oe
	);
	modport ctl (
		output start, len, ext_max, hold, invert,
		input  busy, done, pin_o, pin_oe
	);
endinterface : pulse_if
`default_nettype wire

//--- tick_divider.sv
// Purpose: One-cycle enable pulse at the 1/32 s tick rate
// Assumes: DIV of at least 2
// Notes:   Phase restarts with reset
`timescale 1ns/1ns
`default_nettype none
module tick_divider #(
	parameter int DIV = host_pwr_pkg::TICK_DIV
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	output var  logic tick_o
);
	localparam int W = $clog2(DIV);
	localparam logic [W-1:0] LAST = W'(DIV - 1);

	logic [W-1:0] cnt_q;
	logic         wrap;

	// ==========================================================
	// Free-running divider
	assign wrap = (cnt_q == LAST);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q  <= '0;
			tick_o <= 1'b0;
		end else begin
			cnt_q  <= wrap ? '0 : cnt_q + W'(1);
			tick_o <= wrap;
		end
	end
endmodule : tick_divider
`default_nettype wire

//--- pulse_driver.sv
// Purpose: Timed drive of one host control line, Hi-Z otherwise
// Assumes: tick_i is a one-cycle enable at 1/32 s
// Notes:   First tick of a pulse may be partial, so length is -1 tick
`timescale 1ns/1ns
`default_nettype none
module pulse_driver (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic tick_i,
	pulse_if.drv      p
);
	logic [7:0] cnt_q;
	logic [7:0] ext_q;
	logic       act_q;
	logic       inv_q;
	logic       last;
	logic       extend;

	// ==========================================================
	// End of pulse, with optional extension while held
	assign extend = p.hold && (ext_q != 8'h00);
	assign last   = act_q && tick_i && (cnt_q == 8'h01) && !extend;
	assign p.done = last;
	assign p.busy = act_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			act_q <= 1'b0;
			cnt_q <= 8'h00;
			ext_q <= 8'h00;
			inv_q <= 1'b0;
		end else if (p.start && !act_q) begin
			act_q <= 1'b1;
			cnt_q <= p.len;
			ext_q <= p.ext_max;
			inv_q <= p.invert; // Polarity latched for whole pulse
		end else if (act_q && tick_i) begin
			if (cnt_q != 8'h01) begin
				cnt_q <= cnt_q - 8'h01;
			end else if (extend) begin
				ext_q <= ext_q - 8'h01;
			end else begin
				act_q <= 1'b0; // Back to Hi-Z
			end
		end
	end

	// Drive only during the pulse
	assign p.pin_o  = inv_q;
	assign p.pin_oe = act_q;
endmodule : pulse_driver
`default_nettype wire

//--- host_power_watchdog_ctrl.sv
// Purpose: Host power, reset and watchdog supervisor with Wishbone regs
// Assumes: Keys and host sense are asynchronous, active-high levels
// Notes:   Commands are written as one word; replies read back
//
// The address map and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module host_power_watchdog_ctrl #(
	parameter int TICK_DIV = host_pwr_pkg::TICK_DIV
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output var  logic [31:0] dat_o,
	output var  logic        ack_o,
	input  wire logic        host_sense_i,
	input  wire logic        key_ur_i,
	input  wire logic        key_lr_i,
	output var  logic        host_rst_o,
	output var  logic        host_rst_oe_o,
	output var  logic        host_pwr_o,
	output var  logic        host_pwr_oe_o,
	output var  logic        display_blank_o,
	output var  logic        backlight_on_o,
	output var  logic        restart_o
);
	// ==========================================================
	// Declarations
	host_pwr_pkg::ctl_state_t state_q;
	host_pwr_pkg::ctl_state_t state_d;

	logic [2:0]  sync1_q;
	logic [2:0]  sync2_q;
	logic        host_prev_q;
	logic        host_on;
	logic        host_rise;
	logic        restart_q;
	logic        srst;
	logic        tick;
	logic [7:0]  hold_q [2];
	logic [1:0]  key_s;
	logic [7:0]  mask_q;
	logic [7:0]  plen_q;
	logic [7:0]  wd_cnt_q;
	logic [4:0]  wd_sub_q;
	logic        wd_active;
	logic        wd_fire;
	logic        blank_q;
	logic        ack_q;
	logic [31:0] dat_q;
	logic [7:0]  rep_type_q;
	logic [7:0]  rep_len_q;
	logic        rep_vld_q;
	logic        rep_err_q;
	logic [7:0]  stat_b7_q;
	logic [7:0]  stat_b8_q;
	logic        bus_req;
	logic        bus_wr;
	logic        cmd_wr;
	logic [7:0]  c_type;
	logic [7:0]  c_d0;
	logic [7:0]  c_d1;
	logic [1:0]  c_len;
	logic        ok_pwr;
	logic        ok_wd;
	logic        ok_stat;
	logic        cmd_ok;
	logic        idle;
	logic        key_rst_go;
	logic        pon_go;
	logic        poff_go;
	logic        rst_start;
	logic        pulse_end_restart;
	logic [31:0] rd_mux;
	logic [7:0]  status_b7;

	pulse_if rst_pif ();
	pulse_if pwr_pif ();

	// ==========================================================
	// Input synchronisers: host sense, upper-right, lower-right key
	// Sense chain resets high so a host on at boot is no false rise
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_q <= 3'h1;
			sync2_q <= 3'h1;
		end else begin
			sync1_q <= {key_lr_i, key_ur_i, host_sense_i};
			sync2_q <= sync1_q;
		end
	end

	assign host_on = sync2_q[0];
	assign key_s   = sync2_q[2:1];

	// Edge memory survives soft restart, else restart would repeat
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			host_prev_q <= 1'b1;
		end else begin
			host_prev_q <= host_on;
		end
	end

	assign host_rise = host_on && !host_prev_q;

	// ==========================================================
	// Soft restart: one cycle, clears all control state
	assign srst = rst_i || restart_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			restart_q <= 1'b0;
		end else begin
			restart_q <= host_rise || pulse_end_restart;
		end
	end

	assign restart_o = restart_q;

	// ==========================================================
	// Common 1/32 s tick
	tick_divider #(
		.DIV (TICK_DIV)
	) u_tick (
		.clk_i  (clk_i),
		.rst_i  (srst),
		.tick_o (tick)
	);

	// ==========================================================
	// Key hold timers, saturating; run even while blanked
	for (genvar k = 0; k < 2; k++) begin : g_key
		always_ff @(posedge clk_i) begin
			if (srst || !key_s[k]) begin
				hold_q[k] <= 8'h00;
			end else if (tick && hold_q[k] != 8'hFF) begin
				hold_q[k] <= hold_q[k] + 8'h01;
			end
		end
	end

	// ==========================================================
	// Key actions; equality fires once per hold
	assign key_rst_go = mask_q[host_pwr_pkg::MASK_KEY_RST] && host_on
		&& tick && hold_q[0] == host_pwr_pkg::LONG_HOLD_TICKS;
	assign pon_go     = mask_q[host_pwr_pkg::MASK_KEY_PON] && !host_on
		&& tick && hold_q[0] == host_pwr_pkg::PWRON_HOLD_TICKS;
	assign poff_go    = mask_q[host_pwr_pkg::MASK_KEY_POFF] && host_on
		&& tick && hold_q[1] == host_pwr_pkg::LONG_HOLD_TICKS;
	assign idle       = (state_q == host_pwr_pkg::ST_IDLE);
	assign rst_start  = idle && (wd_fire || key_rst_go);

	// ==========================================================
	// Pulse requests to the line drivers
	assign rst_pif.start   = rst_start;
	assign rst_pif.len     = host_pwr_pkg::RST_PULSE_TICKS;
	assign rst_pif.ext_max = 8'h00;
	assign rst_pif.hold    = 1'b0;
	assign rst_pif.invert  = mask_q[host_pwr_pkg::MASK_RST_INV];

	assign pwr_pif.start   = idle && !rst_start && (poff_go || pon_go);
	assign pwr_pif.len     = plen_q;
	assign pwr_pif.ext_max = (state_d == host_pwr_pkg::ST_POFF) ?
		host_pwr_pkg::EXTEND_TICKS : 8'h00;
	assign pwr_pif.hold    = key_s[1];
	assign pwr_pif.invert  = mask_q[host_pwr_pkg::MASK_PWR_INV];

	pulse_driver u_rst_drv (
		.clk_i  (clk_i),
		.rst_i  (srst),
		.tick_i (tick),
		.p      (rst_pif.drv)
	);

	pulse_driver u_pwr_drv (
		.clk_i  (clk_i),
		.rst_i  (srst),
		.tick_i (tick),
		.p      (pwr_pif.drv)
	);

	// Lines float unless a driver is active
	assign host_rst_o    = rst_pif.pin_o;
	assign host_rst_oe_o = rst_pif.pin_oe;
	assign host_pwr_o    = pwr_pif.pin_o;
	assign host_pwr_oe_o = pwr_pif.pin_oe;

	// ==========================================================
	// Control state machine; commands refused outside idle
	always_comb begin
		state_d = state_q;
		case (state_q)
			host_pwr_pkg::ST_IDLE: begin
				if (rst_start) begin
					state_d = host_pwr_pkg::ST_RST;
				end else if (poff_go) begin
					state_d = host_pwr_pkg::ST_POFF;
				end else if (pon_go) begin
					state_d = host_pwr_pkg::ST_PON;
				end
			end
			host_pwr_pkg::ST_RST: begin
				if (rst_pif.done) begin
					state_d = host_pwr_pkg::ST_IDLE;
				end
			end
			host_pwr_pkg::ST_PON, host_pwr_pkg::ST_POFF: begin
				if (pwr_pif.done) begin
					state_d = host_pwr_pkg::ST_IDLE;
				end
			end
			default: begin
				state_d = host_pwr_pkg::ST_IDLE;
			end
		endcase
	end

	// Reset and power-on pulses end in a device restart
	assign pulse_end_restart =
		(state_q == host_pwr_pkg::ST_RST && rst_pif.done) ||
		(state_q == host_pwr_pkg::ST_PON && pwr_pif.done);

	always_ff @(posedge clk_i) begin
		if (srst) begin
			state_q <= host_pwr_pkg::ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// ==========================================================
	// Wishbone classic slave: ack one cycle after strobe
	assign bus_req = cyc_i && stb_i;
	assign bus_wr  = bus_req && we_i && ack_q; // Takes effect at ack edge
	assign cmd_wr  = bus_wr && adr_i[7:2] == host_pwr_pkg::REG_CMD[7:2]
		&& sel_i == 4'hF; // Partial command words ignored

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else begin
			ack_q <= bus_req && !ack_q;
			if (bus_req && !ack_q && !we_i) begin
				dat_q <= rd_mux;
			end
		end
	end

	assign ack_o = ack_q;
	assign dat_o = dat_q;

	// ==========================================================
	// Read decode; unmapped and command word read as zero
	assign status_b7 = {mask_q[7:4], wd_active, mask_q[2:0]};

	assign rd_mux =
		(adr_i[7:2] == host_pwr_pkg::REG_REPLY[7:2]) ?
			{14'h0000, rep_err_q, rep_vld_q, rep_len_q, rep_type_q} :
		(adr_i[7:2] == host_pwr_pkg::REG_STAT[7:2]) ?
			{16'h0000, stat_b8_q, stat_b7_q} :
		(adr_i[7:2] == host_pwr_pkg::REG_LIVE[7:2]) ?
			{8'h00, mask_q, wd_cnt_q, 3'h0, pwr_pif.busy,
			 rst_pif.busy, wd_active, blank_q, host_on} :
		32'h0000_0000;

	// ==========================================================
	// Command decode
	assign c_type  = dat_i[host_pwr_pkg::CMD_TYPE_LSB +: 8];
	assign c_d0    = dat_i[host_pwr_pkg::CMD_D0_LSB +: 8];
	assign c_d1    = dat_i[host_pwr_pkg::CMD_D1_LSB +: 8];
	assign c_len   = dat_i[host_pwr_pkg::CMD_LEN_LSB +: 2];
	assign ok_pwr  = c_type == host_pwr_pkg::CMD_PWR_FUNC
		&& (c_len == 2'h1 || c_len == 2'h2);
	assign ok_wd   = c_type == host_pwr_pkg::CMD_WATCHDOG && c_len == 2'h1;
	assign ok_stat = c_type == host_pwr_pkg::CMD_STATUS && c_len == 2'h0;
	assign cmd_ok  = idle && (ok_pwr || ok_wd || ok_stat);

	// Function mask and pulse length; bit 3 is status-only
	always_ff @(posedge clk_i) begin
		if (srst) begin
			mask_q <= host_pwr_pkg::MASK_RESET;
			plen_q <= host_pwr_pkg::PULSE_LEN_RESET; // 1 s default
		end else if (cmd_wr && idle && ok_pwr) begin
			mask_q <= c_d0 & 8'hF7;
			if (c_len == 2'h2) begin
				plen_q <= (c_d1 == 8'h00) ? 8'h01 : c_d1;
			end
		end
	end

	// ==========================================================
	// Reply and status snapshot
	always_ff @(posedge clk_i) begin
		if (srst) begin
			rep_type_q <= 8'h00;
			rep_len_q  <= 8'h00;
			rep_vld_q  <= 1'b0;
			rep_err_q  <= 1'b0;
			stat_b7_q  <= 8'h00;
			stat_b8_q  <= 8'h00;
		end else if (cmd_wr) begin
			rep_vld_q  <= 1'b1;
			rep_err_q  <= !cmd_ok;
			rep_type_q <= cmd_ok ? (c_type | host_pwr_pkg::ACK_FLAG) : c_type;
			rep_len_q  <= (cmd_ok && ok_stat) ? host_pwr_pkg::STATUS_LEN : 8'h00;
			if (cmd_ok && ok_stat) begin
				stat_b7_q <= status_b7;
				stat_b8_q <= wd_cnt_q;
			end
		end
	end

	// ==========================================================
	// Watchdog: off after any restart, counts whole seconds
	assign wd_active = (wd_cnt_q != 8'h00);
	assign wd_fire   = wd_active && tick && idle
		&& wd_sub_q == host_pwr_pkg::SECOND_LAST_TICK && wd_cnt_q == 8'h01;

	always_ff @(posedge clk_i) begin
		if (srst) begin
			wd_cnt_q <= 8'h00;
			wd_sub_q <= 5'h00;
		end else if (cmd_wr && idle && ok_wd) begin
			wd_cnt_q <= c_d0; // Zero disables
			wd_sub_q <= 5'h00;
		end else if (wd_active && tick && idle) begin
			if (wd_sub_q == host_pwr_pkg::SECOND_LAST_TICK) begin
				wd_sub_q <= 5'h00;
				wd_cnt_q <= wd_cnt_q - 8'h01;
			end else begin
				wd_sub_q <= wd_sub_q + 5'h01;
			end
		end
	end

	// ==========================================================
	// Display blanking; fan outputs are not touched here
	always_ff @(posedge clk_i) begin
		if (srst) begin
			blank_q <= 1'b0;
		end else begin
			blank_q <= mask_q[host_pwr_pkg::MASK_BLANK] && !host_on;
		end
	end

	assign display_blank_o = blank_q;
	assign backlight_on_o  = !blank_q;

endmodule : host_power_watchdog_ctrl
`default_nettype wire

//--- host_pwr_sva.sv
// Purpose: Port-level checks for the host power supervisor
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to every instance of the top module
`timescale 1ns/1ns
`default_nettype none
module host_pwr_sva #(
	parameter int TICK_DIV = host_pwr_pkg::TICK_DIV
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic ack_o,
	input wire logic host_sense_i,
	input wire logic host_rst_o,
	input wire logic host_rst_oe_o,
	input wire logic host_pwr_o,
	input wire logic host_pwr_oe_o,
	input wire logic display_blank_o,
	input wire logic backlight_on_o,
	input wire logic restart_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// ========
	// Reset pulse length in clocks; first tick may be partial
	int unsigned rst_len_q;
	always_ff @(posedge clk_i) begin
		if (rst_i || !host_rst_oe_o) begin
			rst_len_q <= 0;
		end else begin
			rst_len_q <= rst_len_q + 1;
		end
	end

	// ========
	// Bus handshake
	property p_ack_one;
		ack_o |=> !ack_o;
	endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
	property p_ack_take;
		cyc_i && stb_i && !ack_o |=> ack_o;
	endproperty
	a_ack_take: assert property (p_ack_take) else $error("request not acked");
	property p_ack_cause;
		!(cyc_i && stb_i) |=> !ack_o;
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");

	// ========
	// Display and host lines
	// Blank only follows a host-off level seen through the synchroniser
	property p_backlight;
		display_blank_o |-> !backlight_on_o && !$past(host_sense_i, 3);
	endproperty
	a_backlight: assert property (p_backlight) else $error("blank or backlight wrong");
	property p_blank_on;
		host_sense_i [*4] |=> !display_blank_o;
	endproperty
	a_blank_on: assert property (p_blank_on) else $error("blank while host on");
	property p_rst_len;
		$fell(host_rst_oe_o) |-> rst_len_q >= 31 * TICK_DIV && rst_len_q <= 32 * TICK_DIV + 2;
	endproperty
	a_rst_len: assert property (p_rst_len) else $error("reset pulse not one second");
	property p_rst_restart;
		$fell(host_rst_oe_o) |-> ##[0:4] restart_o;
	endproperty
	a_rst_restart: assert property (p_rst_restart) else $error("no restart after reset");
	property p_rst_level;
		host_rst_oe_o && $past(host_rst_oe_o) |-> $stable(host_rst_o);
	endproperty
	a_rst_level: assert property (p_rst_level) else $error("reset level moved in pulse");
	property p_pwr_level;
		host_pwr_oe_o && $past(host_pwr_oe_o) |-> $stable(host_pwr_o);
	endproperty
	a_pwr_level: assert property (p_pwr_level) else $error("power level moved in pulse");
	property p_sense_restart;
		$rose(host_sense_i) |-> ##[1:5] restart_o;
	endproperty
	a_sense_restart: assert property (p_sense_restart) else $error("no restart on host on");
	property p_restart_one;
		restart_o |=> !restart_o;
	endproperty
	a_restart_one: assert property (p_restart_one) else $error("restart not a pulse");
endmodule : host_pwr_sva

bind host_power_watchdog_ctrl host_pwr_sva #(.TICK_DIV(TICK_DIV)) i_sva (
	.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .host_sense_i, .host_rst_o, .host_rst_oe_o,
	.host_pwr_o, .host_pwr_oe_o, .display_blank_o, .backlight_on_o, .restart_o
);
`default_nettype wire

//--- host_atx_model.sv
// Purpose: Behavioural host board on the power-control line
// Assumes: Host starts powered; sense follows its power state
// Notes:   A press is only acted on once the line is released
`timescale 1ns/1ns
`default_nettype none
module host_atx_model (
	input  wire logic clk_i,
	input  wire logic pwr_oe_i,
	output var  logic sense_o
);
	logic pwr_oe_q = 1'b0;
	logic on_q     = 1'b1; // Host starts powered

	// ========
	// Board toggles its supply at the end of each power pulse
	always @(posedge clk_i) begin
		pwr_oe_q <= pwr_oe_i;
		if (pwr_oe_q && !pwr_oe_i) begin
			on_q <= !on_q;
		end
	end

	// Single driver for the sense pin
	assign sense_o = on_q;
endmodule : host_atx_model
`default_nettype wire

//--- host_power_watchdog_ctrl_test.sv
// Purpose: Self-checking bench for the host power supervisor
// Assumes: TICK_DIV of 8, so one second is 256 clocks
// Notes:   Host model flips sense after each power pulse
`timescale 1ns/1ns
`default_nettype none
module host_power_watchdog_ctrl_test;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc_i = 1'b0;
	logic        stb_i = 1'b0;
	logic        we_i = 1'b0;
	logic [7:0]  adr_i = 8'h00;
	logic [3:0]  sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0;
	logic        key_ur_i = 1'b0;
	logic        key_lr_i = 1'b0;
	logic        host_sense_i;
	logic [31:0] dat_o;
	logic        ack_o, host_rst_o, host_rst_oe_o, host_pwr_o, host_pwr_oe_o;
	logic        display_blank_o, backlight_on_o, restart_o;
	logic [31:0] rd;
	int          errors = 0;
	int          n_compared = 0;

	host_power_watchdog_ctrl #(.TICK_DIV(8)) i_dut (
		.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
		.host_sense_i, .key_ur_i, .key_lr_i, .host_rst_o, .host_rst_oe_o, .host_pwr_o,
		.host_pwr_oe_o, .display_blank_o, .backlight_on_o, .restart_o
	);
	host_atx_model i_host (.clk_i, .pwr_oe_i(host_pwr_oe_o), .sense_o(host_sense_i));

	always #20 clk_i = ~clk_i;

	// ========
	// Compare and bus tasks
	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: word %h, expected %h", $time, got, exp);
		end
	endtask : chk32
	task automatic chk1(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: bit %b, expected %b", $time, got, exp);
		end
	endtask : chk1
	// Classic cycle; request held until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		sel_i <= 4'hF;
		dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		rd = dat_o;
		chk1(ack_o, 1'b1);
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask : wb
	// Command word, then the reply register into rd
	task automatic cmd(input logic [7:0] t, input logic [7:0] d0, input logic [7:0] d1,
			input logic [1:0] n);
		wb(1'b1, host_pwr_pkg::REG_CMD, {6'h00, n, d1, d0, t});
		wb(1'b0, host_pwr_pkg::REG_REPLY, 32'h0);
	endtask : cmd
	function automatic logic pick(input int s);
		case (s)
			0: return host_rst_oe_o;
			1: return host_pwr_oe_o;
			2: return restart_o;
			default: return display_blank_o;
		endcase
	endfunction : pick
	// Bounded wait for a level, then compare what was seen
	task automatic wait_for(input int s, input logic v, input int lim, input logic exp);
		for (int i = 0; i < lim; i++) begin
			@(posedge clk_i);
			if (pick(s) === v) break;
		end
		chk1(pick(s), exp);
	endtask : wait_for
	task automatic conclude;
		$display("Compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : conclude

	// ========
	// Hang guard, well above the roughly 4800 clocks of the run
	initial begin
		repeat (30000) @(posedge clk_i);
		errors++;
		$display("Error at %0t: run timed out", $time);
		conclude();
	end

	// ========
	// Test sequence
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, host_pwr_pkg::REG_LIVE, 32'h0);
		chk32(rd, 32'h0000_0001);
		chk1(host_rst_oe_o | host_pwr_oe_o, 1'b0);
		wb(1'b0, 8'h10, 32'h0);
		chk32(rd, 32'h0);
		cmd(host_pwr_pkg::CMD_PWR_FUNC, 8'h10, 8'h00, 2'd0);
		chk32(rd & 32'h0003_0000, 32'h0003_0000);
		cmd(host_pwr_pkg::CMD_PWR_FUNC, 8'h16, 8'h04, 2'd2);
		chk32(rd, 32'h0001_005C);
		cmd(host_pwr_pkg::CMD_PWR_FUNC, 8'h1E, 8'h00, 2'd1);
		chk32(rd, 32'h0001_005C);
		wb(1'b0, host_pwr_pkg::REG_LIVE, 32'h0);
		chk32(rd, 32'h0016_0001);
		cmd(host_pwr_pkg::CMD_STATUS, 8'h00, 8'h00, 2'd0);
		chk32(rd, 32'h0001_0F5E);
		wb(1'b0, host_pwr_pkg::REG_STAT, 32'h0);
		chk32(rd, 32'h0000_0016);
		$display("test config done");
		// Watchdog kicked once, then left to expire
		cmd(host_pwr_pkg::CMD_WATCHDOG, 8'h02, 8'h00, 2'd1);
		chk32(rd, 32'h0001_005D);
		cmd(host_pwr_pkg::CMD_STATUS, 8'h00, 8'h00, 2'd0);
		wb(1'b0, host_pwr_pkg::REG_STAT, 32'h0);
		chk32(rd, 32'h0000_021E);
		wait_for(0, 1'b1, 300, 1'b0);
		cmd(host_pwr_pkg::CMD_WATCHDOG, 8'h02, 8'h00, 2'd1);
		wait_for(0, 1'b1, 400, 1'b0);
		wait_for(0, 1'b1, 300, 1'b1);
		chk1(host_rst_o, 1'b1);
		wait_for(2, 1'b1, 300, 1'b1);
		wb(1'b0, host_pwr_pkg::REG_LIVE, 32'h0);
		chk32(rd, 32'h0000_0001);
		wait_for(0, 1'b1, 700, 1'b0);
		cmd(host_pwr_pkg::CMD_WATCHDOG, 8'h01, 8'h00, 2'd1);
		cmd(host_pwr_pkg::CMD_WATCHDOG, 8'h00, 8'h00, 2'd1);
		chk32(rd, 32'h0001_005D);
		wait_for(0, 1'b1, 400, 1'b0);
		$display("test watchdog done");
		// Key-held reset, low polarity
		cmd(host_pwr_pkg::CMD_PWR_FUNC, 8'h20, 8'h00, 2'd1);
		key_ur_i <= 1'b1;
		wait_for(0, 1'b1, 1100, 1'b1);
		chk1(host_rst_o, 1'b0);
		key_ur_i <= 1'b0;
		wait_for(2, 1'b1, 300, 1'b1);
		// Power off with extension, blanking, then key power-on
		cmd(host_pwr_pkg::CMD_PWR_FUNC, 8'hD0, 8'h02, 2'd2);
		key_lr_i <= 1'b1;
		wait_for(1, 1'b1, 1100, 1'b1);
		chk1(host_pwr_o, 1'b0);
		cmd(host_pwr_pkg::CMD_STATUS, 8'h00, 8'h00, 2'd0);
		chk32(rd, 32'h0003_001E);
		repeat (100) @(posedge clk_i);
		chk1(host_pwr_oe_o, 1'b1);
		key_lr_i <= 1'b0;
		wait_for(1, 1'b0, 40, 1'b0);
		wait_for(3, 1'b1, 20, 1'b1);
		chk1(backlight_on_o, 1'b0);
		wb(1'b0, host_pwr_pkg::REG_LIVE, 32'h0);
		chk32(rd, 32'h00D0_0002);
		key_ur_i <= 1'b1;
		wait_for(1, 1'b1, 120, 1'b1);
		chk1(host_pwr_o, 1'b0);
		key_ur_i <= 1'b0;
		wait_for(2, 1'b1, 100, 1'b1);
		repeat (8) @(posedge clk_i);
		chk1(display_blank_o, 1'b0);
		wb(1'b0, host_pwr_pkg::REG_LIVE, 32'h0);
		chk32(rd, 32'h0000_0001);
		$display("test keys done");
		conclude();
	end
endmodule : host_power_watchdog_ctrl_test
`default_nettype wire
